/* rtl/rpd_pkg.sv */
// Package for the receive read-back and power-down register bank
package rpd_pkg;
   // ==========================================================
   // Register addresses
   localparam logic [6:0] RPD_ADDR_RX_CFG = 7'h1d;
   localparam logic [6:0] RPD_ADDR_PWR = 7'h1e;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RPD_RX_CFG_RST = 8'h80;
   localparam logic [7:0] RPD_PWR_RST = 8'h07;
   // ==========================================================
   // Field positions, receiver read-back configuration
   localparam int RPD_SEL_LSB = 0;
   localparam int RPD_SEL_MSB = 2;
   localparam int RPD_CONTINUOUS_READBACK_EN_BIT = 3;
   localparam int RPD_FLAG_BIT = 4;
   localparam int RPD_GPO_BIT = 5;
   localparam int RPD_TRUNC_BIT = 6;
   localparam int RPD_192K_BIT = 7;
   // Field positions, power-down control
   localparam int RPD_PLL_BIT = 0;
   localparam int RPD_RXPD_BIT = 1;
   localparam int RPD_TXPD_BIT = 2;
   localparam int RPD_OSC_BIT = 3;
   localparam int RPD_AIF_BIT = 4;
   localparam int RPD_TRI_BIT = 5;
   // ==========================================================
   // Read-back selector codes
   localparam logic [2:0] RPD_SEL_INT = 3'h0;
   localparam logic [2:0] RPD_SEL_CS1 = 3'h1;
   localparam logic [2:0] RPD_SEL_CS5 = 3'h5;
   localparam logic [2:0] RPD_SEL_RXST = 3'h6;
   localparam int RPD_NUM_CS = 5;

   // Status inputs gathered for read-back
   typedef struct packed {
      logic [7:0] int_status;
      logic [RPD_NUM_CS-1:0][7:0] chan_status;
      logic [7:0] rx_status;
   } rpd_status_type;

   // Controls driven to the rest of the device
   typedef struct packed {
      logic continuous_readback_en;
      logic flagged_audio_en;
      logic rx_pins_as_outputs;
      logic rx_truncation_bypass;
      logic rx_high_rate_en;
      logic pll_power_down;
      logic receiver_power_down;
      logic transmitter_power_down;
      logic oscillator_power_down;
      logic audio_port_power_down;
      logic outputs_high_impedance;
   } rpd_ctrl_type;
endpackage : rpd_pkg

/* rtl/rpd_regs.sv */
// Receive read-back configuration and power-down control registers
`timescale 1ns/10ps
module rpd_regs (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Control interface register access
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   // Status read-back
   input wire rpd_pkg::rpd_status_type i_status,
   input wire logic i_status_rd,
   output logic [7:0] o_status_data,
   output logic o_status_valid,
   // Control outputs
   output rpd_pkg::rpd_ctrl_type o_ctrl,
   output logic [2:0] o_readback_select
);
   import rpd_pkg::*;


   // ==========================================================
   // Sizes of the read-back selector
   // Code count follows from the selector width
   localparam int SEL_W = RPD_SEL_MSB - RPD_SEL_LSB + 1;
   localparam int NUM_CODES = 2 ** SEL_W;

   // ==========================================================
   // Storage
   logic [7:0] rx_cfg_r;
   logic [7:0] pwr_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic [7:0] status_r;
   logic status_valid_r;

   // ==========================================================
   // Combinational values
   logic [7:0] rdata_nxt;
   logic [7:0] status_nxt;
   logic [7:0] pwr_wdata;
   logic [SEL_W-1:0] sel;
   logic wr_rx_cfg;
   logic wr_pwr;
   logic rd_rx_cfg;
   logic rd_pwr;
   // One status byte per selector code
   logic [7:0] status_table [NUM_CODES];
   rpd_ctrl_type ctrl;

   // ==========================================================
   // Address decode
   // Writes land on the register whose address matches
   assign wr_rx_cfg = i_wr_en && (i_addr == RPD_ADDR_RX_CFG);
   assign wr_pwr = i_wr_en && (i_addr == RPD_ADDR_PWR);

   // Reads decode the same addresses
   assign rd_rx_cfg = i_rd_en && (i_addr == RPD_ADDR_RX_CFG);
   assign rd_pwr = i_rd_en && (i_addr == RPD_ADDR_PWR);

   // ==========================================================
   // Power write data
   // Bits above the tri-state control are unused and store zero,
   // so a read of the power register always shows them clear
   always_comb begin
      pwr_wdata = 8'h00;
      pwr_wdata[RPD_TRI_BIT:RPD_PLL_BIT] = i_wdata[RPD_TRI_BIT:RPD_PLL_BIT];
   end

   // ==========================================================
   // Receiver read-back configuration register
   // Selector in the low bits, receive mode controls above it
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         // Selector starts on interrupt status, high rate enabled
         rx_cfg_r <= RPD_RX_CFG_RST;
      end else if (wr_rx_cfg) begin
         rx_cfg_r <= i_wdata;
      end
   end

   // ==========================================================
   // Power-down control register
   // A write takes effect on the edge that takes the strobe
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         // PLL, receiver and transmitter start powered down
         pwr_r <= RPD_PWR_RST;
      end else if (wr_pwr) begin
         pwr_r <= pwr_wdata;
      end
   end

   // ==========================================================
   // Register read data
   // Unmapped addresses return zero. A write and a read in one
   // cycle return the contents from before the write.
   always_comb begin
      rdata_nxt = 8'h00;
      if (rd_rx_cfg) begin
         rdata_nxt = rx_cfg_r;
      end else if (rd_pwr) begin
         rdata_nxt = pwr_r;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rdata_r <= 8'h00;
      end else if (i_rd_en) begin
         rdata_r <= rdata_nxt;
      end
   end

   // One-cycle valid pulse, one clock after the read strobe
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= i_rd_en;
      end
   end

   // ==========================================================
   // Status read-back table
   assign sel = rx_cfg_r[RPD_SEL_MSB:RPD_SEL_LSB];

   // One entry per selector code
   for (genvar code = 0; code < NUM_CODES; code++) begin : g_status_entry
      if (code == int'(RPD_SEL_INT)) begin : g_int
         // Interrupt status at the lowest code
         assign status_table[code] = i_status.int_status;
      end else if (code >= int'(RPD_SEL_CS1) && code <= int'(RPD_SEL_CS5)) begin : g_chan
         // Channel status one follows interrupt status
         assign status_table[code] = i_status.chan_status[code - int'(RPD_SEL_CS1)];
      end else if (code == int'(RPD_SEL_RXST)) begin : g_rx
         // Receiver status after the channel status bytes
         assign status_table[code] = i_status.rx_status;
      end else begin : g_none
         // Unused top code reads zero
         assign status_table[code] = 8'h00;
      end
   end

   // The selector is looked at on the edge that takes the read
   assign status_nxt = status_table[sel];

   // Status data holds until the next status read
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         status_r <= 8'h00;
      end else if (i_status_rd) begin
         status_r <= status_nxt;
      end
   end

   // One-cycle valid pulse, one clock after the status strobe
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         status_valid_r <= 1'b0;
      end else begin
         status_valid_r <= i_status_rd;
      end
   end

   // ==========================================================
   // Control levels to the rest of the device
   always_comb begin
      ctrl = '0;
      // Status bytes repeat without a new read command
      ctrl.continuous_readback_en = rx_cfg_r[RPD_CONTINUOUS_READBACK_EN_BIT];
      // Status flags ride along with the audio words
      ctrl.flagged_audio_en = rx_cfg_r[RPD_FLAG_BIT];
      // Receive pins four to seven drive general outputs
      ctrl.rx_pins_as_outputs = rx_cfg_r[RPD_GPO_BIT];
      // Received words keep their full length
      ctrl.rx_truncation_bypass = rx_cfg_r[RPD_TRUNC_BIT];
      // Receiver accepts rates up to the high limit
      ctrl.rx_high_rate_en = rx_cfg_r[RPD_192K_BIT];

      // Power-down controls, all active high
      // Clock generation stops
      ctrl.pll_power_down = pwr_r[RPD_PLL_BIT];
      // Receiver stops
      ctrl.receiver_power_down = pwr_r[RPD_RXPD_BIT];
      // Transmitter stops
      ctrl.transmitter_power_down = pwr_r[RPD_TXPD_BIT];
      // Crystal oscillator stops
      ctrl.oscillator_power_down = pwr_r[RPD_OSC_BIT];
      // Audio data port stops
      ctrl.audio_port_power_down = pwr_r[RPD_AIF_BIT];
      // Every output pin floats
      ctrl.outputs_high_impedance = pwr_r[RPD_TRI_BIT];
   end

   // ==========================================================
   // Outputs
   // Data outputs all come straight from flip-flops
   assign o_rdata = rdata_r;
   assign o_rvalid = rvalid_r;
   assign o_status_data = status_r;
   assign o_status_valid = status_valid_r;
   assign o_readback_select = sel;

   // Controls are plain levels from the register bits
   assign o_ctrl = ctrl;
endmodule : rpd_regs

/* verif/rpd_regs_props.sv */
// Port assertions for the read-back and power-down registers
`timescale 1ns/10ps
module rpd_regs_props (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Register access
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [6:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic o_rvalid,
   // Status and controls
   input wire rpd_pkg::rpd_status_type i_status,
   input wire logic i_status_rd,
   input wire logic [7:0] o_status_data,
   input wire logic o_status_valid,
   input wire rpd_pkg::rpd_ctrl_type o_ctrl,
   input wire logic [2:0] o_readback_select
);
   import rpd_pkg::*;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   a_rd_answer: assert property (i_rd_en |=> o_rvalid) else $error("read not answered");
   a_rvalid_cause: assert property (o_rvalid |-> $past(i_rd_en)) else $error("stray valid");
   a_stat_answer: assert property (i_status_rd |=> o_status_valid)
      else $error("status not answered");
   a_sel_write: assert property (i_wr_en && i_addr == RPD_ADDR_RX_CFG |=>
      o_readback_select == $past(i_wdata[2:0]) && o_ctrl.rx_high_rate_en == $past(i_wdata[7]))
      else $error("config write lost");
   a_pwr_write: assert property (i_wr_en && i_addr == RPD_ADDR_PWR |=>
      o_ctrl.pll_power_down == $past(i_wdata[0]) &&
      o_ctrl.outputs_high_impedance == $past(i_wdata[5])) else $error("power write lost");
   a_sel_hold: assert property (!(i_wr_en && i_addr == RPD_ADDR_RX_CFG) |=>
      $stable(o_readback_select)) else $error("selector moved");
   a_int_pick: assert property (i_status_rd && o_readback_select == RPD_SEL_INT |=>
      o_status_data == $past(i_status.int_status)) else $error("wrong interrupt status");
   a_rx_pick: assert property (i_status_rd && o_readback_select == RPD_SEL_RXST |=>
      o_status_data == $past(i_status.rx_status)) else $error("wrong receiver status");
   a_reset_vals: assert property (disable iff (1'b0) !i_rst_b |=>
      o_ctrl.rx_high_rate_en && o_ctrl.transmitter_power_down && !o_ctrl.audio_port_power_down)
      else $error("bad reset value");
endmodule : rpd_regs_props
bind rpd_regs rpd_regs_props props (
   .i_mclk(i_mclk),
   .i_rst_b(i_rst_b),
   .i_wr_en(i_wr_en),
   .i_rd_en(i_rd_en),
   .i_addr(i_addr),
   .i_wdata(i_wdata),
   .o_rdata(o_rdata),
   .o_rvalid(o_rvalid),
   .i_status(i_status),
   .i_status_rd(i_status_rd),
   .o_status_data(o_status_data),
   .o_status_valid(o_status_valid),
   .o_ctrl(o_ctrl),
   .o_readback_select(o_readback_select)
);

/* verif/rx_readback_and_powerdown_regs_test.sv */
// Self-checking bench for the read-back and power-down registers
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %0t got %h", $time, a); end end
module rx_readback_and_powerdown_regs_test;
   import rpd_pkg::*;
   logic i_mclk = 0, i_rst_b = 0, i_wr_en = 0, i_rd_en = 0, i_status_rd = 0;
   logic [6:0] i_addr = 7'h00;
   logic [7:0] i_wdata = 8'h00, o_rdata, o_status_data, cfg, pwr;
   logic o_rvalid, o_status_valid;
   logic [2:0] o_readback_select;
   rpd_ctrl_type o_ctrl;
   rpd_status_type i_status = {8'ha0, 8'hb5, 8'hb4, 8'hb3, 8'hb2, 8'hb1, 8'hc6};
   int fail_count = 0, tests_run = 0;
   // Rows of address, write data, expected read-back
   logic [22:0] rows [5] = '{{7'h1d, 8'hff, 8'hff}, {7'h1e, 8'hff, 8'h3f},
      {7'h1f, 8'h55, 8'h00}, {7'h1e, 8'h00, 8'h00}, {7'h1d, 8'h2a, 8'h2a}};
   rpd_regs dut (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en),
      .i_addr(i_addr),
      .i_wdata(i_wdata),
      .o_rdata(o_rdata),
      .o_rvalid(o_rvalid),
      .i_status(i_status),
      .i_status_rd(i_status_rd),
      .o_status_data(o_status_data),
      .o_status_valid(o_status_valid),
      .o_ctrl(o_ctrl),
      .o_readback_select(o_readback_select)
   );
   // Control levels expected from the two register values
   function automatic rpd_ctrl_type exp_ctrl(input logic [7:0] c, input logic [7:0] p);
      return {c[3], c[4], c[5], c[6], c[7], p[0], p[1], p[2], p[3], p[4], p[5]};
   endfunction : exp_ctrl
   initial begin
      forever #25 i_mclk = ~i_mclk;
   end
   task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_wr_en <= w;
      i_rd_en <= !w;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr_en <= 1'b0;
      i_rd_en <= 1'b0;
      #1;
   endtask : acc
   task automatic results;
      $display("Checks %0d, failures %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : results
   initial begin
      #200us;
      fail_count++;
      results;
   end
   initial begin
      repeat (16) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      cfg = 8'h80;
      pwr = 8'h07;
      acc(1'b0, 7'h1d, 8'h00);
      `CHK(o_rdata, 8'h80)
      `CHK(o_rvalid, 1'b1)
      `CHK(o_ctrl, exp_ctrl(cfg, pwr))
      `CHK(o_readback_select, 3'h0)
      acc(1'b0, 7'h1e, 8'h00);
      `CHK(o_rdata, 8'h07)
      for (int k = 0; k < 5; k++) begin
         acc(1'b1, rows[k][22:16], rows[k][15:8]);
         `CHK(o_rvalid, 1'b0)
         if (rows[k][22:16] == 7'h1d) cfg = rows[k][15:8];
         if (rows[k][22:16] == 7'h1e) pwr = rows[k][15:8];
         acc(1'b0, rows[k][22:16], 8'h00);
         `CHK(o_rdata, rows[k][7:0])
         `CHK(o_rvalid, 1'b1)
         `CHK(o_ctrl, exp_ctrl(cfg, pwr))
      end
      for (int s = 0; s < 8; s++) begin
         acc(1'b1, 7'h1d, 8'(s));
         `CHK(o_readback_select, 3'(s))
         @(posedge i_mclk);
         i_status_rd <= 1'b1;
         @(posedge i_mclk);
         i_status_rd <= 1'b0;
         #1;
         `CHK(o_status_valid, 1'b1)
         `CHK(o_status_data, s == 0 ? 8'ha0 : s < 6 ? 8'hb0 + 8'(s) : s == 6 ? 8'hc6 : 8'h00)
      end
      @(posedge i_mclk);
      i_rst_b <= 1'b0;
      @(posedge i_mclk);
      i_rst_b <= 1'b1;
      acc(1'b0, 7'h1e, 8'h00);
      `CHK(o_rdata, 8'h07)
      acc(1'b0, 7'h1d, 8'h00);
      `CHK(o_rdata, 8'h80)
      `CHK(o_ctrl, exp_ctrl(8'h80, 8'h07))
      results;
   end
endmodule : rx_readback_and_powerdown_regs_test
